// *** rtc_pkg.sv ***
`default_nettype none
package rtc_pkg;
  // ==========================================================
  // Register word addresses on the on-chip peripheral bus
  // ==========================================================
  localparam logic [15:0] ADDR_RTC_CONTROL     = 16'hec00; // Control and flags
  localparam logic [15:0] ADDR_PRESCALER_LOW   = 16'hec02; // Prescaler bits 15..0
  localparam logic [15:0] ADDR_PRESCALER_HIGH  = 16'hec04; // Prescaler bits 19..16
  localparam logic [15:0] ADDR_DIVIDER_LOW     = 16'hec0a; // Divider bits 15..0, read only
  localparam logic [15:0] ADDR_DIVIDER_HIGH    = 16'hec0c; // Divider bits 19..16, read only
  localparam logic [15:0] ADDR_TIME_COUNT_LOW  = 16'hec0e; // Time counter low half
  localparam logic [15:0] ADDR_TIME_COUNT_HIGH = 16'hec10; // Time counter high half
  localparam logic [15:0] ADDR_ALARM_LOW       = 16'hec12; // Alarm low half
  localparam logic [15:0] ADDR_ALARM_HIGH      = 16'hec14; // Alarm high half

  // ==========================================================
  // Control register field positions
  // ==========================================================
  localparam int BIT_TICK_FLAG   = 0; // Tick request flag
  localparam int BIT_TICK_EN     = 1; // Tick request enable
  localparam int BIT_ALARM_FLAG  = 2; // Alarm request flag
  localparam int BIT_ALARM_EN    = 3; // Alarm request enable
  localparam int BIT_SWITCH_OFF  = 7; // Switch-off bit

  // ==========================================================
  // Reset values and fixed counts
  // ==========================================================
  localparam logic [15:0] RTC_CONTROL_RESET = 16'h0000; // Control after reset
  localparam logic [5:0]  PREDIV_LAST       = 6'h3f;    // Fixed divide-by-64 terminal

  // Bus request carried as one bundle
  typedef struct packed {
    logic        sel;   // Access strobe
    logic        wr;    // High for write
    logic [15:0] addr;  // Byte address
    logic [15:0] wdata; // Write data
  } bus_req_t;
endpackage
`default_nettype wire

// *** rtc_prescaler_counter_alarm.sv ***
// Behaviour
// [R01] Runs from the oscillator clock through power down
// [R02] Fixed divide-by-64 ahead of divider
// [R03] Divider is 4-bit upper plus 16-bit lower
// [R04] Divider reloads prescaler at each tick
// [R05] Tick period is 64 times prescaler
// [R06] Prescaler split into high 4, low 16
// [R07] Prescaler registers survive every reset
// [R08] Prescaler writes only while switch-off set
// [R09] Time counter increments once per tick
// [R10] Periodic tick request on each tick
// [R11] Alarm request when counter equals alarm
// [R12] Switch-off stops counters, unlocks, oscillator off; code turns the oscillator off only while powerdown_in is also high
// [R13] Switch-off clear keeps running in power down
// [R14] Alarm enable gates alarm request
// [R15] Tick enable gates tick request
// [R16] Alarm flag set on alarm; code sets it only while alarm enable is set
// [R17] Tick flag set on each tick; code sets it only while tick enable is set
// [R18] Request lines usable as wake interrupts
// [R19] Control register readable and writable
// [R20] Prescaler change reloads the divider
// [R21] Time halves load on write, read count
// [R22] Time writes only while switch-off set
// [R23] Counters and registers survive system reset; the control register is cleared to zero by rst_in
// [R24] Flags stay set until software writes zero
// [R25] Alarm raised once on the matching tick
`timescale 1ns/1ps
`default_nettype none
module rtc_prescaler_counter_alarm
  import rtc_pkg::*;
#(
  parameter int DIV_WIDTH = 20, // Divider width
  parameter int CNT_WIDTH = 32  // Time counter width
) (
  input  wire logic        clk_in,          // Oscillator-derived clock
  input  wire logic        rst_in,          // Synchronous reset, active high
  input  wire bus_req_t    bus_in,          // Peripheral bus request
  input  wire logic        powerdown_in,    // Chip is in power down
  output logic [15:0]      rdata_out,       // Registered read data
  output logic             tick_irq_out,    // Tick request line
  output logic             alarm_irq_out,   // Alarm request line
  output logic             osc_enable_out   // Oscillator keep-running
);

  // ==========================================================
  // State
  // ==========================================================
  logic [15:0]          rtc_control;     // Control register
  logic [3:0]           prescaler_high;  // Prescaler top bits, not reset
  logic [15:0]          prescaler_low;   // Prescaler low bits, not reset
  logic [5:0]           prediv;          // Fixed predivider
  logic [3:0]           divider_high;    // Upper divider counter
  logic [15:0]          divider_low;     // Lower divider counter
  logic [15:0]          time_count_high; // Time counter high half
  logic [15:0]          time_count_low;  // Time counter low half
  logic [15:0]          alarm_value_high;// Alarm high half
  logic [15:0]          alarm_value_low; // Alarm low half
  logic                 reload_pending;  // Prescaler changed, reload divider
  logic                 tick_irq;        // Registered tick request
  logic                 alarm_irq;       // Registered alarm request

  // ==========================================================
  // Decode
  // ==========================================================
  // Write strobe to a given address
  function automatic logic wr_hit(input bus_req_t r, input logic [15:0] a);
    wr_hit = r.sel && r.wr && (r.addr == a);
  endfunction

  logic switch_off_bit;  // Counters stopped, registers unlocked
  logic pre_end;         // Predivider wraps this cycle
  logic div_end;         // Divider expires this cycle
  logic ref_tick;        // Basic reference tick
  logic [DIV_WIDTH-1:0] prescaler_value; // Joined prescaler
  logic [DIV_WIDTH-1:0] divider_value;   // Joined divider
  logic [DIV_WIDTH-1:0] next_divider;    // Divider next count
  logic [CNT_WIDTH-1:0] time_count;      // Joined time counter
  logic [CNT_WIDTH-1:0] next_time;       // Incremented time
  logic                 alarm_match;     // Incremented counter equals alarm
  logic                 ctl_wr;          // Control write

  assign switch_off_bit  = rtc_control[BIT_SWITCH_OFF];
  // [R03] [R06] Halves joined
  assign prescaler_value = {prescaler_high, prescaler_low};
  assign divider_value   = {divider_high, divider_low};
  assign time_count      = {time_count_high, time_count_low};
  // [R02] Divide by 64
  assign pre_end         = (prediv == PREDIV_LAST);
  // [R05] Divider counts up and expires at all ones, so period is the prescaler count
  assign next_divider    = divider_value + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
  assign div_end         = pre_end && (next_divider == '0);
  assign ref_tick        = div_end && !switch_off_bit;
  assign next_time       = time_count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
  // [R11] Equality compare
  assign alarm_match     = (next_time == {alarm_value_high, alarm_value_low});
  assign ctl_wr          = wr_hit(bus_in, ADDR_RTC_CONTROL);

  // ==========================================================
  // Control register
  // ==========================================================
  // [R19] [R24] Software writes; flags clear on zero, hardware set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rtc_control <= RTC_CONTROL_RESET;
    end else begin
      if (ctl_wr) begin
        rtc_control[BIT_SWITCH_OFF] <= bus_in.wdata[BIT_SWITCH_OFF];
        rtc_control[BIT_ALARM_EN]   <= bus_in.wdata[BIT_ALARM_EN];
        rtc_control[BIT_TICK_EN]    <= bus_in.wdata[BIT_TICK_EN];
        rtc_control[BIT_ALARM_FLAG] <= rtc_control[BIT_ALARM_FLAG] & bus_in.wdata[BIT_ALARM_FLAG];
        rtc_control[BIT_TICK_FLAG]  <= rtc_control[BIT_TICK_FLAG] & bus_in.wdata[BIT_TICK_FLAG];
      end
      // [R17] [R15] Tick flag
      if (ref_tick && rtc_control[BIT_TICK_EN]) begin
        rtc_control[BIT_TICK_FLAG] <= 1'b1;
      end
      // [R16] [R14] Alarm flag
      if (ref_tick && alarm_match && rtc_control[BIT_ALARM_EN]) begin
        rtc_control[BIT_ALARM_FLAG] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Prescaler registers, never reset
  // ==========================================================
  // [R07] [R08] Locked unless switch-off set
  always_ff @(posedge clk_in) begin
    if (switch_off_bit && wr_hit(bus_in, ADDR_PRESCALER_HIGH)) begin
      prescaler_high <= bus_in.wdata[3:0];
    end
    if (switch_off_bit && wr_hit(bus_in, ADDR_PRESCALER_LOW)) begin
      prescaler_low <= bus_in.wdata;
    end
  end

  // [R20] Note any change so the divider picks it up
  always_ff @(posedge clk_in) begin
    if (switch_off_bit && (wr_hit(bus_in, ADDR_PRESCALER_HIGH)
                           || wr_hit(bus_in, ADDR_PRESCALER_LOW))) begin
      reload_pending <= 1'b1;
    end else begin
      reload_pending <= 1'b0;
    end
  end

  // ==========================================================
  // Predivider and divider, never reset
  // ==========================================================
  // [R12] [R13] Stopped by switch-off only, runs through power down
  // [R01] Counts on the oscillator-derived clock
  always_ff @(posedge clk_in) begin
    if (switch_off_bit) begin
      // Parked at zero while stopped, so a restart has a known phase
      prediv <= 6'h00;
    end else begin
      prediv <= prediv + 6'h01;
    end
  end

  // [R04] [R20] Reload at tick or prescaler change; load is two's complement
  always_ff @(posedge clk_in) begin
    if (reload_pending || div_end) begin
      {divider_high, divider_low} <= DIV_WIDTH'(0) - prescaler_value;
    end else if (pre_end && !switch_off_bit) begin
      {divider_high, divider_low} <= next_divider;
    end
  end

  // ==========================================================
  // Time counter and alarm, never reset
  // ==========================================================
  // [R09] [R21] [R22] [R23] Tick advance, direct load while stopped
  always_ff @(posedge clk_in) begin
    if (ref_tick) begin
      {time_count_high, time_count_low} <= next_time;
    end else begin
      if (switch_off_bit && wr_hit(bus_in, ADDR_TIME_COUNT_HIGH)) begin
        time_count_high <= bus_in.wdata;
      end
      if (switch_off_bit && wr_hit(bus_in, ADDR_TIME_COUNT_LOW)) begin
        time_count_low <= bus_in.wdata;
      end
    end
  end

  // Alarm halves are unprotected
  always_ff @(posedge clk_in) begin
    if (wr_hit(bus_in, ADDR_ALARM_HIGH)) begin
      alarm_value_high <= bus_in.wdata;
    end
    if (wr_hit(bus_in, ADDR_ALARM_LOW)) begin
      alarm_value_low <= bus_in.wdata;
    end
  end

  // ==========================================================
  // Request lines
  // ==========================================================
  // [R10] [R18] [R25] One-cycle pulses on the tick, alarm only at first match
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_irq  <= 1'b0;
      alarm_irq <= 1'b0;
    end else begin
      tick_irq  <= ref_tick && rtc_control[BIT_TICK_EN];
      alarm_irq <= ref_tick && alarm_match && rtc_control[BIT_ALARM_EN];
    end
  end
  assign tick_irq_out  = tick_irq;
  assign alarm_irq_out = alarm_irq;
  // [R12] [R13] Oscillator off only in power down with switch-off set
  assign osc_enable_out = !(powerdown_in && switch_off_bit);

  // ==========================================================
  // Read data
  // ==========================================================
  // Registered read; unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else if (bus_in.sel && !bus_in.wr) begin
      case (bus_in.addr)
        ADDR_RTC_CONTROL:     rdata_out <= rtc_control & 16'h008f;
        ADDR_PRESCALER_LOW:   rdata_out <= prescaler_low;
        ADDR_PRESCALER_HIGH:  rdata_out <= {12'h000, prescaler_high};
        ADDR_DIVIDER_LOW:     rdata_out <= divider_low;
        ADDR_DIVIDER_HIGH:    rdata_out <= {12'h000, divider_high};
        ADDR_TIME_COUNT_LOW:  rdata_out <= time_count_low;
        ADDR_TIME_COUNT_HIGH: rdata_out <= time_count_high;
        ADDR_ALARM_LOW:       rdata_out <= alarm_value_low;
        ADDR_ALARM_HIGH:      rdata_out <= alarm_value_high;
        default:              rdata_out <= 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_tick_pulse_gated: assert property (@(posedge clk_in) disable iff (rst_in) // [R15]
    tick_irq_out |-> $past(rtc_control[BIT_TICK_EN]))
    else $error("tick request without enable");
  a_tick_flag_set: assert property (@(posedge clk_in) disable iff (rst_in) // [R17]
    tick_irq_out |-> rtc_control[BIT_TICK_FLAG])
    else $error("tick flag not set");
  a_alarm_flag_set: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
    alarm_irq_out |-> rtc_control[BIT_ALARM_FLAG])
    else $error("alarm flag not set");
  a_alarm_once: assert property (@(posedge clk_in) disable iff (rst_in) // [R25]
    alarm_irq_out |=> !alarm_irq_out)
    else $error("alarm request repeated");
  a_stop_holds: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    switch_off_bit && $past(switch_off_bit) && !$past(ctl_wr) |-> !tick_irq_out)
    else $error("tick while stopped");
  a_time_advance: assert property (@(posedge clk_in) disable iff (rst_in) // [R09]
    ref_tick |=> time_count == $past(time_count) + 32'h1)
    else $error("time counter not advanced");
  a_prescale_lock: assert property (@(posedge clk_in) // [R08]
    !switch_off_bit |=> $stable(prescaler_value))
    else $error("prescaler changed while locked");
  a_flag_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [R24]
    rtc_control[BIT_TICK_FLAG] && !ctl_wr |=> rtc_control[BIT_TICK_FLAG])
    else $error("tick flag dropped");
  a_osc_off: assert property (@(posedge clk_in) // [R13]
    !switch_off_bit |-> osc_enable_out)
    else $error("oscillator stopped while running");

  // ==========================================================
  // Named steps shared by the multi-cycle checks
  // ==========================================================
  // Enabled tick reaching the request logic
  sequence s_tick_enabled;
    ref_tick && rtc_control[BIT_TICK_EN];
  endsequence

  // Enabled alarm match reaching the request logic
  sequence s_alarm_enabled;
    ref_tick && alarm_match && rtc_control[BIT_ALARM_EN];
  endsequence

  // Unlocked write to the low prescaler half
  sequence s_open_prescale_low;
    switch_off_bit && wr_hit(bus_in, ADDR_PRESCALER_LOW);
  endsequence

  // Unlocked write to the low time half
  sequence s_open_time_low;
    switch_off_bit && wr_hit(bus_in, ADDR_TIME_COUNT_LOW);
  endsequence

  // Locked write to either time half, with no tick in the same cycle
  sequence s_locked_time;
    !switch_off_bit && !ref_tick
      && (wr_hit(bus_in, ADDR_TIME_COUNT_HIGH) || wr_hit(bus_in, ADDR_TIME_COUNT_LOW));
  endsequence

  // Counters stopped on two edges in a row
  sequence s_stopped_two;
    switch_off_bit ##1 switch_off_bit;
  endsequence

  // Software clears the tick flag while no enabled tick sets it
  sequence s_tick_clear;
    ctl_wr && !bus_in.wdata[BIT_TICK_FLAG] && !(ref_tick && rtc_control[BIT_TICK_EN]);
  endsequence

  // ==========================================================
  // Checks built from the named steps
  // ==========================================================
  // Enabled tick gives a request pulse on the next edge
  a_tick_pulse_follows: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    s_tick_enabled |=> tick_irq_out)
    else $error("tick request missing");
  // Enabled match gives an alarm pulse on the next edge
  a_alarm_pulse_follows: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
    s_alarm_enabled |=> alarm_irq_out)
    else $error("alarm request missing");
  // No alarm pulse unless enabled when the match was seen
  a_alarm_gated: assert property (@(posedge clk_in) disable iff (rst_in) // [R14]
    alarm_irq_out |-> $past(rtc_control[BIT_ALARM_EN]))
    else $error("alarm request without enable");
  // Each tick reloads the divider with the negated prescaler
  a_divider_reload: assert property (@(posedge clk_in) disable iff (rst_in) // [R04]
    ref_tick |=> (divider_value + $past(prescaler_value)) == '0)
    else $error("divider not reloaded at tick");
  // Unlocked low prescaler write lands as written
  a_prescale_load: assert property (@(posedge clk_in) disable iff (rst_in) // [R06]
    s_open_prescale_low |=> prescaler_low == $past(bus_in.wdata))
    else $error("prescaler low half not loaded");
  // Unlocked low time write lands as written
  a_time_load: assert property (@(posedge clk_in) disable iff (rst_in) // [R21]
    s_open_time_low |=> time_count_low == $past(bus_in.wdata))
    else $error("time low half not loaded");
  // Locked time write leaves the counter alone
  a_time_locked: assert property (@(posedge clk_in) disable iff (rst_in) // [R22]
    s_locked_time |=> $stable(time_count))
    else $error("time changed by locked write");
  // Predivider parked at zero while stopped
  a_stop_parks: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    s_stopped_two |-> prediv == 6'h00)
    else $error("predivider running while stopped");
  // Oscillator released in power down with switch-off set
  a_osc_stop: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
    powerdown_in && switch_off_bit |-> !osc_enable_out)
    else $error("oscillator kept on in power down");
  // Written zero clears the tick flag
  a_flag_clear: assert property (@(posedge clk_in) disable iff (rst_in) // [R24]
    s_tick_clear |=> !rtc_control[BIT_TICK_FLAG])
    else $error("tick flag not cleared");
  // Tick request is a single-cycle pulse for edge-triggered wake
  a_tick_once: assert property (@(posedge clk_in) disable iff (rst_in) // [R18]
    tick_irq_out |=> !tick_irq_out)
    else $error("tick request longer than one cycle");

endmodule // rtc_prescaler_counter_alarm
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtc_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic        clk_in;         // Bench clock, 50 MHz
  logic        rst_in;         // Synchronous reset
  logic        powerdown_in;   // Power-down level
  bus_req_t    bus_in;         // Bus request bundle
  logic [15:0] rdata_out;      // Read data
  logic        tick_irq_out;   // Tick pulse
  logic        alarm_irq_out;  // Alarm pulse
  logic        osc_enable_out; // Oscillator keep-running
  logic [15:0] exp_q[$];       // Expected read data, oldest first
  logic        rd_take = 1'b0; // Read sampled on the last edge
  int          fails = 0;      // Mismatch count
  int          tests_run = 0;  // Comparison count
  int          cyc = 0;        // Cycle count for the timeout
  int          ticks = 0;      // Tick pulses seen
  int          alarms = 0;     // Alarm pulses seen
  int          t_last = 0;     // Cycle of the last tick
  int          period = 0;     // Cycles between last two ticks
  logic [15:0] pre;            // Prescaler under test
  logic [31:0] tval;           // Start time
  logic [31:0] tend;           // Expected time after seven ticks
  logic [31:0] talarm;         // Alarm value under test
  logic [19:0] dneg;           // Divider right after a reload

  rtc_prescaler_counter_alarm DUT (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .bus_in         (bus_in),
    .powerdown_in   (powerdown_in),
    .rdata_out      (rdata_out),
    .tick_irq_out   (tick_irq_out),
    .alarm_irq_out  (alarm_irq_out),
    .osc_enable_out (osc_enable_out)
  );

  // ==========================================================
  // Clock, pulse watcher and timeout
  // ==========================================================
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Count pulses and time the tick spacing
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    rd_take <= bus_in.sel && !bus_in.wr;
    if (tick_irq_out === 1'b1) begin
      ticks <= ticks + 1;
      period <= cyc - t_last;
      t_last <= cyc;
    end
    if (alarm_irq_out === 1'b1) alarms <= alarms + 1;
    // A hang ends the run as a failure
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end

  // Read data lands one edge after the strobe
  always @(negedge clk_in) begin
    if (rd_take === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "read without note");
      else chk(rdata_out === exp_q.pop_front(), "read data");
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // One bus cycle, strobe held for one edge
  task automatic bus_op(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    bus_in = '{1'b1, w, a, d};
    @(posedge clk_in);
    #1;
    bus_in.sel = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_op(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus_op(1'b0, a, 16'h0000);
  endtask

  task automatic close_out;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_in = 1'b1;
    powerdown_in = 1'b0;
    bus_in = '0;
    void'($urandom(32'h756d2565));
    pre = 16'h0002 + 16'($urandom_range(3));
    tval = $urandom;
    tend = tval + 32'h0000_0007;
    talarm = tval + 32'h0000_0003;
    dneg = 20'h00000 - {4'h0, pre};
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    rd(ADDR_RTC_CONTROL, RTC_CONTROL_RESET);
    rd(16'hec20, 16'h0000);
    wr(ADDR_RTC_CONTROL, 16'h0080);
    wr(ADDR_PRESCALER_LOW, pre);
    wr(ADDR_PRESCALER_HIGH, 16'h0000);
    wr(ADDR_TIME_COUNT_LOW, tval[15:0]);
    wr(ADDR_TIME_COUNT_HIGH, tval[31:16]);
    wr(ADDR_ALARM_LOW, talarm[15:0]);
    wr(ADDR_ALARM_HIGH, talarm[31:16]);
    rd(ADDR_PRESCALER_HIGH, 16'h0000);
    rd(ADDR_TIME_COUNT_LOW, tval[15:0]);
    // Run with both requests enabled, then try locked writes
    wr(ADDR_RTC_CONTROL, 16'h000a);
    wr(ADDR_PRESCALER_LOW, ~pre);
    wr(ADDR_TIME_COUNT_HIGH, ~tval[31:16]);
    rd(ADDR_PRESCALER_LOW, pre);
    wait (ticks >= 4);
    #1;
    chk(period == 64 * pre, "tick period");
    chk(alarms == 1, "alarm count");
    rd(ADDR_RTC_CONTROL, 16'h000f);
    wr(ADDR_RTC_CONTROL, 16'h000a);
    rd(ADDR_RTC_CONTROL, 16'h000a);
    wait (ticks >= 7);
    chk(alarms == 1, "alarm repeated");
    // Stop right after a tick and read the count
    wr(ADDR_RTC_CONTROL, 16'h0080);
    rd(ADDR_TIME_COUNT_LOW, tend[15:0]);
    rd(ADDR_TIME_COUNT_HIGH, tend[31:16]);
    rd(ADDR_DIVIDER_LOW, dneg[15:0]);
    rd(ADDR_DIVIDER_HIGH, {12'h000, dneg[19:16]});
    powerdown_in = 1'b1;
    repeat (300) @(posedge clk_in);
    #1;
    chk(osc_enable_out === 1'b0, "oscillator kept on");
    chk(ticks == 7, "ticks while stopped");
    rd(ADDR_TIME_COUNT_LOW, tend[15:0]);
    // Alarm one tick ahead, to be met with its enable clear
    talarm = tend + 32'h0000_0001;
    wr(ADDR_ALARM_LOW, talarm[15:0]);
    wr(ADDR_ALARM_HIGH, talarm[31:16]);
    // Running in power down with the tick request disabled
    wr(ADDR_RTC_CONTROL, 16'h0000);
    chk(osc_enable_out === 1'b1, "oscillator off");
    repeat (128 * pre + 8) @(posedge clk_in);
    chk(ticks == 7, "disabled tick");
    #1;
    chk(alarms == 1, "disabled alarm");
    rd(ADDR_RTC_CONTROL, 16'h0000);
    // Stop, load a fresh time, and see it survive a reset
    wr(ADDR_RTC_CONTROL, 16'h0080);
    wr(ADDR_TIME_COUNT_LOW, ~tval[15:0]);
    wr(ADDR_TIME_COUNT_HIGH, ~tval[31:16]);
    powerdown_in = 1'b0;
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    rd(ADDR_RTC_CONTROL, RTC_CONTROL_RESET);
    rd(ADDR_PRESCALER_LOW, pre);
    rd(ADDR_TIME_COUNT_LOW, ~tval[15:0]);
    rd(ADDR_TIME_COUNT_HIGH, ~tval[31:16]);
    repeat (3) @(posedge clk_in);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
